/* File: inc/csci_pkg.sv */
// Constants and carrier types for the card status-change interrupt block.
// Assumes a register port addressed by the printed byte index of each register.

package csci_pkg;

  // ---------------------------------------------------------------------------
  // Register indices and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CSCI_FLAGS_IDX  = 8'h04;
  localparam logic [7:0] CSCI_CFG_IDX    = 8'h05;
  localparam logic [7:0] CSCI_CFG_RESET  = 8'h00;
  localparam logic [3:0] CSCI_FLAG_RESET = 4'h0;
  localparam logic [7:0] CSCI_RDATA_RST  = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CSCI_ROUTE_LSB     = 4;
  localparam int CSCI_ROUTE_MSB     = 7;
  localparam int CSCI_BIT_DETECT    = 3;
  localparam int CSCI_BIT_READY     = 2;
  localparam int CSCI_BIT_BATLOW    = 1;
  localparam int CSCI_BIT_BATTERY_DEAD_FLAG   = 0;

  // ---------------------------------------------------------------------------
  // Route select codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CSCI_ROUTE_NONE = 4'h0;
  localparam logic [3:0] CSCI_ROUTE_SMI  = 4'h2;

  // Card-side levels, sampled on the system clock.
  typedef struct packed {
    logic card_detect_one;
    logic card_detect_two;
    logic card_ready;
    logic battery_low_line;
    logic card_status_change_line;
    logic ring_indicate_input;
  } csci_card_s;

  // Socket mode bits held in neighbouring registers.
  typedef struct packed {
    logic io_card;
    logic ring_enable;
    logic diag_pci_route;
    logic route_status_to_pci;
    logic clear_by_write;
  } csci_mode_s;

endpackage

/* File: hdl/csci_top.sv */
// Card status-change flag and interrupt configuration registers with routing.
// Assumes card pins and mode bits are synchronous to clk_sys and that the
// register port issues single-cycle read and write strobes.
//
// How it works
// - Flag bits 7..4 read zero, ignore writes
// - Bit 3 sets on any detect line change
// - Bit 2 sets on ready rise, memory card
// - Bit 2 reads zero for I/O card
// - Bit 1 sets on battery low, memory card
// - Bit 1 reads zero for I/O card
// - Bit 0 records battery dead, memory card
// - Bit 0 follows status-change line level, I/O card
// - Ring mode: bit 0 follows ring indicate
// - Config bits 7..4 are read/write route select
// - Code 0 with diag bit routes to PCI
// - Code 0, diag clear: no ISA routing
// - Diag clear: PCI only when route bit set
// - Decode none, IRQ1, SMI, other IRQ lines
// - Disabled source flag always reads zero
// - Clear by read or write-one, mode-selected
// - Config bits 3..0 enable the four sources
// - Enabled event sets flag, raises routed interrupt

`timescale 1ns/1ps
`default_nettype none

module csci_top (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_wdata,
  output var  logic [7:0]         reg_rdata_q,
  // Card pins and socket mode
  input  wire csci_pkg::csci_card_s card,
  input  wire csci_pkg::csci_mode_s mode,
  // Interrupt routes
  output var  logic               irq_pci_q,
  output var  logic               irq_smi_q,
  output var  logic [15:0]        irq_isa_q
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [3:0] flag_q;
  logic       primed_q;
  logic       cd1_q;
  logic       cd2_q;
  logic       ready_q;
  logic [3:0] set_c;
  logic [3:0] clr_c;
  logic [3:0] view_c;
  logic [3:0] route_c;
  logic [3:0] en_c;
  logic       mem_card_c;
  logic       pending_c;
  logic       to_pci_c;
  logic       hit_flags_c;
  logic       hit_cfg_c;

  assign en_c        = cfg_q[3:0];
  assign route_c     = cfg_q[csci_pkg::CSCI_ROUTE_MSB:csci_pkg::CSCI_ROUTE_LSB];
  assign mem_card_c  = ~mode.io_card;
  assign hit_flags_c = (reg_addr == csci_pkg::CSCI_FLAGS_IDX);
  assign hit_cfg_c   = (reg_addr == csci_pkg::CSCI_CFG_IDX);

  // ---------------------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------------------
  // Whole byte is read/write: route select on top, source enables below.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_q <= csci_pkg::CSCI_CFG_RESET;
    end else if (reg_wr && hit_cfg_c) begin
      cfg_q <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------------------
  // Previous pin levels; the first cycle after reset only primes them so a
  // card already seated at power-up is not reported as a change.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      primed_q <= 1'b0;
      cd1_q    <= 1'b0;
      cd2_q    <= 1'b0;
      ready_q  <= 1'b0;
    end else begin
      primed_q <= 1'b1;
      cd1_q    <= card.card_detect_one;
      cd2_q    <= card.card_detect_two;
      ready_q  <= card.card_ready;
    end
  end

  // Set terms per source, each gated by its enable.
  always_comb begin
    set_c    = 4'h0;
    set_c[3] = primed_q & en_c[3] &
               ((card.card_detect_one ^ cd1_q) | (card.card_detect_two ^ cd2_q));
    set_c[2] = primed_q & en_c[2] & mem_card_c & card.card_ready & ~ready_q;
    set_c[1] = en_c[1] & mem_card_c & card.battery_low_line;
    set_c[0] = en_c[0] & mem_card_c & card.card_status_change_line;
  end

  // Clear terms: a flags read clears all in read mode, a write of ones
  // clears chosen bits in write mode; the other method is ignored.
  always_comb begin
    clr_c = 4'h0;
    if (reg_rd && hit_flags_c && !mode.clear_by_write) begin
      clr_c = 4'hf;
    end else if (reg_wr && hit_flags_c && mode.clear_by_write) begin
      clr_c = reg_wdata[3:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Sticky flags
  // ---------------------------------------------------------------------------
  // Set beats clear so an event landing on the clearing access is kept.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          flag_q[gi] <= csci_pkg::CSCI_FLAG_RESET[gi];
        end else begin
          flag_q[gi] <= set_c[gi] | (flag_q[gi] & ~clr_c[gi]);
        end
      end
    end
  endgenerate

  // Visible flags: disabled sources and memory-only bits on I/O cards read 0.
  // Bit 0 is a live level in I/O and ring modes, so it cannot be held there.
  always_comb begin
    view_c    = flag_q & en_c;
    view_c[2] = flag_q[2] & en_c[2] & mem_card_c;
    view_c[1] = flag_q[1] & en_c[1] & mem_card_c;
    if (mode.ring_enable) begin
      view_c[0] = en_c[0] & card.ring_indicate_input;
    end else if (mode.io_card) begin
      view_c[0] = en_c[0] & card.card_status_change_line;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  // Returns the value seen before any clear that the same read triggers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_q <= csci_pkg::CSCI_RDATA_RST;
    end else if (reg_rd) begin
      if (hit_flags_c) begin
        reg_rdata_q <= {4'h0, view_c};
      end else if (hit_cfg_c) begin
        reg_rdata_q <= cfg_q;
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt routing
  // ---------------------------------------------------------------------------
  assign pending_c = |view_c;
  assign to_pci_c  = mode.diag_pci_route ? (route_c == csci_pkg::CSCI_ROUTE_NONE)
                                         : mode.route_status_to_pci;

  // Level interrupts that follow pending flags; ISA lines are dropped when the
  // PCI route wins, which keeps one event from being serviced twice.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_pci_q <= 1'b0;
      irq_smi_q <= 1'b0;
      irq_isa_q <= 16'h0000;
    end else begin
      irq_pci_q <= pending_c & to_pci_c;
      irq_smi_q <= pending_c & ~to_pci_c & (route_c == csci_pkg::CSCI_ROUTE_SMI);
      irq_isa_q <= 16'h0000;
      if (pending_c && !to_pci_c && route_c != csci_pkg::CSCI_ROUTE_NONE
          && route_c != csci_pkg::CSCI_ROUTE_SMI) begin
        irq_isa_q[route_c] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_upper_zero;
    reg_rd && hit_flags_c |=> reg_rdata_q[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("flag upper bits nonzero");

  property p_detect_set;
    primed_q && en_c[3] &&
      (card.card_detect_one != cd1_q || card.card_detect_two != cd2_q) |=> flag_q[3];
  endproperty
  a_detect_set: assert property (p_detect_set) else $error("detect change lost");

  property p_ready_cause;
    $rose(flag_q[2]) |-> $past(card.card_ready) && !$past(ready_q) && $past(en_c[2])
                         && $past(mem_card_c);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready flag without rise");

  property p_io_zero;
    reg_rd && hit_flags_c && mode.io_card |=> reg_rdata_q[2:1] == 2'b00;
  endproperty
  a_io_zero: assert property (p_io_zero) else $error("memory-only bits on io card");

  property p_batlow;
    en_c[1] && mem_card_c && card.battery_low_line |=> flag_q[1];
  endproperty
  a_batlow: assert property (p_batlow) else $error("battery low not flagged");

  property p_card_status_change_line_live;
    mode.io_card && !mode.ring_enable && en_c[0] |-> view_c[0] == card.card_status_change_line;
  endproperty
  a_card_status_change_line_live: assert property (p_card_status_change_line_live) else $error("status line not followed");

  property p_ring;
    mode.ring_enable && en_c[0] |-> view_c[0] == card.ring_indicate_input;
  endproperty
  a_ring: assert property (p_ring) else $error("ring input not followed");

  property p_cfg_write;
    reg_wr && hit_cfg_c |=> cfg_q == $past(reg_wdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_pci_route;
    pending_c && to_pci_c |=> irq_pci_q && irq_isa_q == 16'h0000 && !irq_smi_q;
  endproperty
  a_pci_route: assert property (p_pci_route) else $error("pci route wrong");

  property p_no_isa;
    route_c == csci_pkg::CSCI_ROUTE_NONE |=> irq_isa_q == 16'h0000 && !irq_smi_q;
  endproperty
  a_no_isa: assert property (p_no_isa) else $error("isa line with no route");

  property p_smi;
    pending_c && !to_pci_c && route_c == csci_pkg::CSCI_ROUTE_SMI |=> irq_smi_q;
  endproperty
  a_smi: assert property (p_smi) else $error("smi not raised");

  property p_disabled;
    (view_c & ~en_c) == 4'h0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled source visible");

  property p_read_clear;
    reg_rd && hit_flags_c && !mode.clear_by_write && set_c == 4'h0 |=> flag_q == 4'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_sticky;
    flag_q[3] && !clr_c[3] |=> flag_q[3] [*1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  c_detect_irq: cover property (set_c[3] ##[1:4] irq_pci_q);
  c_isa_irq:    cover property (pending_c && !to_pci_c ##1 irq_isa_q != 16'h0000);
  c_wr_clear:   cover property (flag_q[1] && reg_wr && hit_flags_c && mode.clear_by_write);

endmodule

`default_nettype wire

/* File: tb/csci_card_model.sv */
// Behavioural card that stands in the socket for the status-change bench.
// Assumes the bench sets the wanted pin levels between falling edges.

`timescale 1ns/1ps
`default_nettype none

module csci_card_model (
  // Clock and wanted pin levels
  input  wire logic                 clk_sys,
  input  wire logic [5:0]           want,
  // Card pins
  output var  csci_pkg::csci_card_s card
);
  // Pins move on the falling edge so the sampling edge never races them.
  initial card = '0;
  always @(negedge clk_sys) begin
    card <= want;
  end
endmodule

`default_nettype wire

/* File: tb/tb_card_status_change_interrupt.sv */
// Self-checking bench for the status-change flags, enables and routing.
// Assumes csci_top and the card model; reads are checked from a queue.

`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end

module tb_card_status_change_interrupt;
  logic                 clk_sys = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic                 rd_d = 1'b0;
  logic [7:0]           reg_addr = 8'h00;
  logic [7:0]           reg_wdata = 8'h00;
  logic [7:0]           reg_rdata_q;
  logic [7:0]           r;
  logic [5:0]           want = 6'h00;
  logic                 irq_pci_q;
  logic                 irq_smi_q;
  logic [15:0]          irq_isa_q;
  logic [25:0]          note;
  logic [25:0]          q[$];
  csci_pkg::csci_mode_s mode = '0;
  csci_pkg::csci_card_s card;
  int                   num_errors = 0;
  int                   compares = 0;
  int                   seed = 50;

  // Free-running system clock.
  always #12.5 clk_sys = ~clk_sys;

  csci_top i_csci_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .card(card),
    .mode(mode), .irq_pci_q(irq_pci_q), .irq_smi_q(irq_smi_q), .irq_isa_q(irq_isa_q)
  );

  csci_card_model i_csci_card_model (.clk_sys(clk_sys), .want(want), .card(card));

  // Expected interrupt outputs for a select code while some flag is set.
  function logic [17:0] route(input logic [3:0] sel, input logic hit);
    logic to_pci;
    to_pci = mode.diag_pci_route ? (sel == 4'h0) : mode.route_status_to_pci;
    if (!hit || (!to_pci && sel == 4'h0)) return 18'h00000;
    if (to_pci) return 18'h20000;
    if (sel == 4'h2) return 18'h10000;
    return {2'b00, 16'h0001 << sel};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // A read notes its expected data and interrupt outputs before the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [17:0] i);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    q.push_back({e, i});
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask

  // Pin change, then enough edges for model, flag and interrupt stages.
  task automatic pins(input logic [5:0] w);
    @(negedge clk_sys);
    want = w;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic report_and_stop;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Answer lands one edge after the read edge; interrupts show pre-clear flags.
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d) begin
      `CHK("note queue", 1'b1, q.size() > 0)
      note = q.pop_front();
      `CHK("read data", note[25:18], reg_rdata_q)
      `CHK("interrupts", note[17:0], {irq_pci_q, irq_smi_q, irq_isa_q})
    end
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(8'h05, 8'h00, 18'h0);
    rd(8'h04, 8'h00, 18'h0);
    rd(8'h07, 8'h00, 18'h0);
    // Random configuration values must read back whole.
    repeat (4) begin
      r = $random(seed);
      wr(8'h05, r);
      rd(8'h05, r, 18'h0);
    end
    wr(8'h04, 8'hf0);
    rd(8'h04, 8'h00, 18'h0);
    // Every select code under each routing mode, detect change as the cause.
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 16; s++) begin
        mode.diag_pci_route = m[0];
        mode.route_status_to_pci = m[1];
        wr(8'h05, {s[3:0], 4'h8});
        pins(want ^ (s[0] ? 6'h10 : 6'h20));
        rd(8'h04, 8'h08, route(s[3:0], 1'b1));
        rd(8'h04, 8'h00, 18'h0);
      end
    end
    // Memory card: ready rise and battery low; low re-sets until removed.
    mode = '0;
    wr(8'h05, 8'h1f);
    pins(6'h0c);
    rd(8'h04, 8'h06, route(4'h1, 1'b1));
    pins(6'h00);
    rd(8'h04, 8'h02, route(4'h1, 1'b1));
    rd(8'h04, 8'h00, 18'h0);
    // Write-one clear: reads leave the sticky battery dead flag alone.
    mode.clear_by_write = 1'b1;
    pins(6'h02);
    pins(6'h00);
    rd(8'h04, 8'h01, route(4'h1, 1'b1));
    rd(8'h04, 8'h01, route(4'h1, 1'b1));
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h00, 18'h0);
    // I/O card: bits 2 and 1 stay zero, bit 0 follows the status line.
    mode = '0;
    mode.io_card = 1'b1;
    pins(6'h0e);
    rd(8'h04, 8'h01, route(4'h1, 1'b1));
    pins(6'h0c);
    rd(8'h04, 8'h00, 18'h0);
    mode.ring_enable = 1'b1;
    pins(6'h0d);
    rd(8'h04, 8'h01, route(4'h1, 1'b1));
    // Sources masked off never show, whatever the pins do.
    wr(8'h05, 8'h10);
    pins(6'h2d);
    rd(8'h04, 8'h00, 18'h0);
    for (int k = 0; k < 20 && q.size() > 0; k++) @(negedge clk_sys);
    if (q.size() > 0) num_errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire
